/* File: core/branch_skip_consts.vh */
// constants for the conditional branch and skip unit
`ifndef BRANCH_SKIP_CONSTS_VH
`define BRANCH_SKIP_CONSTS_VH
`define OP_HI_BRANCH    4'he
`define OP_BR_CARRY     4'h3
`define OP_BR_NEG       4'h7
`define OP_BIT_CLR      4'hb
`define OP_BIT_SET      4'ha
`define OP_INC_HI       4'h3
`define OP_INC_LO       2'h3
`define IDX_LIMIT       8'h5f
`define ACCESS_HI_BASE  8'h60
`define BANK_ACCESS_LO  4'h0
`define BANK_ACCESS_HI  4'hf
`define PC_STEP         21'h000002
`define PC_RESET        21'h000000
`define FSR2_BANK_W     12
`endif

/* File: core/branch_skip_unit.v */
// execution of conditional branch, bit-test skip and increment skip instructions
// Contract
// - target is fetch address plus two plus twice offset
// - branch one cycle, taken two
// - skip when tested bit clear
// - skip when tested bit set
// - increment file, write to w or file
// - skip squashes fetched instruction as no-op
// - skipping two-word instruction costs three cycles
// - access bit selects access or banked
// - extended set indexes addresses up to 95
`timescale 1ns/1ps
module branch_skip_unit (
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  input  wire        instr_valid_i,
  input  wire [15:0] instr_i,
  input  wire [20:0] pc_i,
  input  wire        carry_i,
  input  wire        negative_i,
  input  wire [3:0]  bank_select_reg_i,
  input  wire        ext_set_en_i,
  input  wire [11:0] fsr2_i,
  input  wire [7:0]  file_rdata_i,
  input  wire        next_two_word_i,
  output reg         pc_load_o,
  output reg  [20:0] pc_target_o,
  output reg         squash_o,
  output reg  [11:0] file_addr_o,
  output reg         file_we_o,
  output reg         w_we_o,
  output reg  [7:0]  result_o,
  output reg         busy_o,
  output wire        flags_we_o
);
`include "branch_skip_consts.vh"

  localparam ST_RUN  = 2'd0;
  localparam ST_NOP1 = 2'd1;
  localparam ST_NOP2 = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  // registered output next values
  reg         pc_load_nxt;
  reg  [20:0] pc_target_nxt;
  reg         squash_nxt;
  reg  [11:0] file_addr_nxt;
  reg         file_we_nxt;
  reg         w_we_nxt;
  reg  [7:0]  result_nxt;
  reg         busy_nxt;
  wire [11:0] addr_w;
  wire        is_bc;
  wire        is_bn;
  wire        is_btc;
  wire        is_bts;
  wire        is_inc;
  wire        bit_val;
  wire [7:0]  inc_val;
  wire        take_br;
  wire        do_skip;
  wire        exec;
  wire        bit_skip;
  wire        inc_skip;
  wire        flow_break;

  function [20:0] branch_target;
    input [20:0] pc;
    input [7:0]  off;
    begin
      branch_target = pc + `PC_STEP + {{12{off[7]}}, off, 1'b0};
    end
  endfunction

  // upper byte match for the two relative branches
  function branch_op;
    input [15:0] instr;
    input [3:0]  lo;
    begin
      branch_op = (instr[15:12] == `OP_HI_BRANCH) & (instr[11:8] == lo);
    end
  endfunction

  file_addr_gen u_addr (
    .f_addr_i          (instr_i[7:0]),
    .access_a_i        (instr_i[8]),
    .bank_select_reg_i (bank_select_reg_i),
    .ext_set_en_i      (ext_set_en_i),
    .fsr2_i            (fsr2_i),
    .addr_o            (addr_w),
    .indexed_o         ()
  );

  assign exec    = instr_valid_i & (state_r == ST_RUN);
  assign is_bc   = branch_op(instr_i, `OP_BR_CARRY);
  assign is_bn   = branch_op(instr_i, `OP_BR_NEG);
  assign is_btc  = (instr_i[15:12] == `OP_BIT_CLR);
  assign is_bts  = (instr_i[15:12] == `OP_BIT_SET);
  assign is_inc  = (instr_i[15:12] == `OP_INC_HI) & (instr_i[11:10] == `OP_INC_LO);
  assign bit_val = file_rdata_i[instr_i[11:9]];
  assign inc_val = file_rdata_i + 8'h01;
  assign take_br = exec & ((is_bc & ~carry_i) | (is_bn & ~negative_i));

  assign bit_skip   = (is_btc & ~bit_val) | (is_bts & bit_val);
  assign inc_skip   = is_inc & (inc_val == 8'h00);
  assign do_skip    = exec & (bit_skip | inc_skip);

  // branch or skip breaks the flow
  assign flow_break = take_br | do_skip;

  assign flags_we_o = 1'b0;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (take_br) begin
          state_nxt = ST_NOP2;
        end else if (do_skip & next_two_word_i) begin
          state_nxt = ST_NOP1;
        end else if (do_skip) begin
          state_nxt = ST_NOP2;
        end
      end
      ST_NOP1: begin
        state_nxt = ST_NOP2;
      end
      ST_NOP2: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // next values of the branch outputs
  always @* begin
    pc_load_nxt   = 1'b0;
    pc_target_nxt = pc_target_o;
    if (take_br) begin
      pc_load_nxt   = 1'b1;
      pc_target_nxt = branch_target(pc_i, instr_i[7:0]);
    end
  end

  // next values of the skip and file outputs
  always @* begin
    squash_nxt    = 1'b0;
    busy_nxt      = (state_nxt != ST_RUN);
    file_addr_nxt = addr_w;
    file_we_nxt   = 1'b0;
    w_we_nxt      = 1'b0;
    result_nxt    = result_o;
    if (flow_break) begin
      squash_nxt = 1'b1;
    end
    if (exec & is_inc) begin
      result_nxt  = inc_val;
      file_we_nxt = instr_i[9];
      w_we_nxt    = ~instr_i[9];
    end
  end

  // state register
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_load_o   <= 1'b0;
      pc_target_o <= `PC_RESET;
    end else begin
      pc_load_o   <= pc_load_nxt;
      pc_target_o <= pc_target_nxt;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      squash_o <= 1'b0;
      busy_o   <= 1'b0;
    end else begin
      squash_o <= squash_nxt;
      busy_o   <= busy_nxt;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      file_addr_o <= 12'h000;
      file_we_o   <= 1'b0;
      w_we_o      <= 1'b0;
      result_o    <= 8'h00;
    end else begin
      file_addr_o <= file_addr_nxt;
      file_we_o   <= file_we_nxt;
      w_we_o      <= w_we_nxt;
      result_o    <= result_nxt;
    end
  end
endmodule // branch_skip_unit

/* File: core/file_addr_gen.v */
// file register address generation: access, banked and indexed literal offset
`timescale 1ns/1ps
module file_addr_gen (
  input  wire [7:0]  f_addr_i,
  input  wire        access_a_i,
  input  wire [3:0]  bank_select_reg_i,
  input  wire        ext_set_en_i,
  input  wire [11:0] fsr2_i,
  output wire [11:0] addr_o,
  output wire        indexed_o
);
`include "branch_skip_consts.vh"
  assign indexed_o = ext_set_en_i & ~access_a_i & (f_addr_i <= `IDX_LIMIT);
  assign addr_o = indexed_o ? (fsr2_i + {4'h0, f_addr_i}) :
                  access_a_i ? {bank_select_reg_i, f_addr_i} :
                  (f_addr_i >= `ACCESS_HI_BASE) ? {`BANK_ACCESS_HI, f_addr_i} :
                  {`BANK_ACCESS_LO, f_addr_i};
endmodule // file_addr_gen

/* File: tb/bsu_monitor.sv */
// assertion checker for the branch skip unit
`timescale 1ns/1ps
module bsu_monitor (
  input wire        clk_sys_i, resetn_i, instr_valid_i, carry_i, negative_i,
  input wire        next_two_word_i, busy_o, pc_load_o, squash_o, w_we_o, file_we_o,
  input wire        flags_we_o,
  input wire        ext_set_en_i,
  input wire [3:0]  bank_select_reg_i,
  input wire [11:0] fsr2_i,
  input wire [11:0] file_addr_o,
  input wire [15:0] instr_i,
  input wire [20:0] pc_i, pc_target_o,
  input wire [7:0]  file_rdata_i, result_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire go = instr_valid_i && !busy_o;
  wire [20:0] tgt = pc_i + 21'h2 + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  wire bit_v = file_rdata_i[instr_i[11:9]];
  wire bt = go && instr_i[15:13] == 3'h5;
  wire inc = go && instr_i[15:10] == 6'h0f;
  wire fa = bt || inc;
  wire [7:0] fadr = instr_i[7:0];
  wire idx = ext_set_en_i && !instr_i[8] && fadr <= 8'h5f;
  sequence noop_s; squash_o && busy_o; endsequence
  flags_kept_a: assert property (!flags_we_o)
    else $error("flags written");
  carry_take_a: assert property (go && instr_i[15:8] == 8'he3 && !carry_i
    |=> pc_load_o && pc_target_o == $past(tgt)) else $error("bad branch target");
  branch_cyc_a: assert property (go && instr_i[15:8] == 8'he7 && !negative_i
    |=> noop_s and pc_load_o ##1 !busy_o) else $error("bad taken timing");
  no_branch_a: assert property (go && instr_i[15:8] == 8'he3 && carry_i
    |=> !pc_load_o && !busy_o) else $error("branch not expected");
  skip_one_a: assert property (bt && bit_v != instr_i[12] && !next_two_word_i
    |=> noop_s ##1 !busy_o) else $error("bad skip timing");
  skip_two_a: assert property (bt && bit_v != instr_i[12] && next_two_word_i
    |=> noop_s ##1 busy_o ##1 !busy_o) else $error("bad two word skip");
  no_skip_a: assert property (bt && bit_v == instr_i[12]
    |=> !squash_o && !busy_o) else $error("skip not expected");
  inc_dest_a: assert property (inc |=> result_o == $past(file_rdata_i) + 8'h1
    && file_we_o == $past(instr_i[9]) && w_we_o != $past(instr_i[9])) else $error("bad inc");
  inc_skip_a: assert property (inc && file_rdata_i == 8'hff |=> noop_s)
    else $error("inc skip missing");
  set_skip_a: assert property (go && instr_i[15:12] == 4'ha && bit_v |=> noop_s)
    else $error("set skip missing");
  neg_hold_a: assert property (go && instr_i[15:8] == 8'he7 && negative_i
    |=> !pc_load_o && !squash_o) else $error("negative branch not expected");
  nop_quiet_a: assert property (busy_o |=> !pc_load_o && !file_we_o && !w_we_o)
    else $error("instruction ran in no-op cycle");
  addr_banked_a: assert property (fa && instr_i[8]
    |=> file_addr_o == $past({bank_select_reg_i, fadr})) else $error("bad banked address");
  addr_access_a: assert property (fa && !instr_i[8] && !idx
    |=> file_addr_o == $past({{4{fadr >= 8'h60}}, fadr})) else $error("bad access address");
  addr_index_a: assert property (fa && idx
    |=> file_addr_o == $past(fsr2_i + {4'h0, fadr})) else $error("bad indexed address");
endmodule // bsu_monitor
bind branch_skip_unit bsu_monitor mon_u (.*);

/* File: tb/test_conditional_branch_skip_unit.sv */
// random self-checking bench for the branch skip unit
`timescale 1ns/1ps
module test_conditional_branch_skip_unit;
  logic clk_sys_i = 0, resetn_i = 0, instr_valid_i = 0, carry_i = 0, negative_i = 0;
  logic next_two_word_i = 0, ext_set_en_i = 0;
  logic [15:0] instr_i = 0;
  logic [20:0] pc_i = 0;
  logic [3:0]  bank_select_reg_i = 0;
  logic [11:0] fsr2_i = 0;
  logic [7:0]  file_rdata_i = 0;
  wire pc_load_o, squash_o, file_we_o, w_we_o, busy_o, flags_we_o;
  wire [20:0] pc_target_o;
  wire [11:0] file_addr_o;
  wire [7:0]  result_o;
  int err_total = 0, checks_done = 0, n;
  logic [20:0] q[$];
  branch_skip_unit dut_u (.*);
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task check(input [20:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    #2;
    if (pc_load_o === 1'b1) check(pc_target_o, q.size() ? q.pop_front() : '1);
    if ((file_we_o | w_we_o) === 1'b1)
      check({13'h0, result_o}, q.size() ? q.pop_front() : '1);
  end
  initial begin
    void'($urandom(62953));
    repeat (3) @(posedge clk_sys_i);
    #1 resetn_i = 1;
    for (n = 0; n < 600; n++) begin
      case ($urandom % 4)
        0: instr_i = {8'he3, 8'($urandom)};
        1: instr_i = {8'he7, 8'($urandom)};
        2: instr_i = {6'h0f, 10'($urandom)};
        default: instr_i = {3'h5, 13'($urandom)};
      endcase
      {carry_i, negative_i, next_two_word_i, ext_set_en_i, bank_select_reg_i, fsr2_i, pc_i} =
        41'({$urandom, $urandom});
      file_rdata_i = n[2] ? 8'hff : 8'($urandom);
      instr_valid_i = 1;
      if (instr_i[15:8] == 8'he3 && !carry_i || instr_i[15:8] == 8'he7 && !negative_i)
        q.push_back(pc_i + 21'h2 + {{12{instr_i[7]}}, instr_i[7:0], 1'b0});
      if (instr_i[15:10] == 6'h0f) q.push_back({13'h0, file_rdata_i + 8'h1});
      @(posedge clk_sys_i);
      #1;
      while (busy_o !== 1'b0) begin
        instr_valid_i = n[0];
        instr_i = 16'($urandom);
        @(posedge clk_sys_i);
        #1;
      end
    end
    repeat (4) @(posedge clk_sys_i);
    check(21'(q.size()), 21'h0);
    $display("random test done");
    close_out;
  end
  initial begin
    #80000;
    err_total++;
    close_out;
  end
endmodule // test_conditional_branch_skip_unit
